// ===== inc/gpio_pins_params.svh
// Summary of operation
// - First port has seven independent tri-state bits, each input or output.
// - First port direction and pull-up follow per-bit register bits.
// - Second port has five independent tri-state bits, each input or output.
// - Second port direction and pull-up follow per-bit register bits.
// - Reset makes all port bits inputs with pull-ups off.
// - Low reset pin holds the device in reset; power-on low resets.
// - After reset pin rises, wait for stable clock before reset processing.
// - Port bit zero written plus software reset drives reset pin low.
// - Reset pin drive is open-drain: pulls low or releases only.
// - Reset pin has an internal pull-up holding it high.
`ifndef GPIO_PINS_PARAMS_SVH
`define GPIO_PINS_PARAMS_SVH
`define P0_WIDTH 7
`define P1_WIDTH 5
`define ADDR_P0_OUT 12'h000
`define ADDR_P0_DIR 12'h004
`define ADDR_P0_PLU 12'h008
`define ADDR_P0_IN 12'h00C
`define ADDR_P1_OUT 12'h010
`define ADDR_P1_DIR 12'h014
`define ADDR_P1_PLU 12'h018
`define ADDR_P1_IN 12'h01C
`define ADDR_RST_CTRL 12'h020
`define ADDR_RST_STAT 12'h024
`define STAB_CYCLES 16'h0400
`define SWRST_PULSE_CYCLES 8'h10
`endif

// ===== inc/gpio_pins_pkg.sv
package gpio_pins_pkg;
	typedef enum logic [2:0] {
		RST_HOLD = 3'b001,
		RST_STAB = 3'b010,
		RST_RUN = 3'b100
	} rst_state_t;
	typedef struct packed {
		logic [6:0] dir;
		logic [6:0] plu;
		logic [6:0] dout;
	} port0_cfg_t;
	typedef struct packed {
		logic [4:0] dir;
		logic [4:0] plu;
		logic [4:0] dout;
	} port1_cfg_t;
endpackage : gpio_pins_pkg

// ===== logic/gpio_pins.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pins_params.svh"
module gpio_pins (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Port pins
	input wire logic [6:0] port0_in,
	output logic [6:0] port0_out,
	output logic [6:0] port0_oe,
	output logic [6:0] port0_pullup_en,
	input wire logic [4:0] port1_in,
	output logic [4:0] port1_out,
	output logic [4:0] port1_oe,
	output logic [4:0] port1_pullup_en,
	// Reset pin, open-drain
	input wire logic reset_pin_active_low_in,
	output logic reset_pin_active_low_out,
	output logic reset_pin_active_low_oe,
	output logic reset_pin_pullup_en,
	// Core reset control
	output logic core_reset,
	output logic reset_irq_req
);
	// ==========================================================
	// Register state
	gpio_pins_pkg::port0_cfg_t p0;
	gpio_pins_pkg::port1_cfg_t p1;
	logic reset_pin_port_bit;
	logic sw_reset_req;
	logic [7:0] swrst_cnt;
	logic [15:0] stab_cnt;
	gpio_pins_pkg::rst_state_t state;
	gpio_pins_pkg::rst_state_t next_state;
	logic aw_held, w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic pin_low;

	// ==========================================================
	// Write channel: address and data taken in either order
	// Readies drop while bvalid stands, so one write is under way at a time
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_bresp = 2'b00;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Configuration registers; reset gives inputs, pull-ups off
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			p0 <= '0;
			p1 <= '0;
			reset_pin_port_bit <= 1'b1;
			sw_reset_req <= 1'b0;
		end else begin
			sw_reset_req <= 1'b0;
			if (do_write && w_strb[0]) begin
				case (aw_addr)
					`ADDR_P0_OUT: p0.dout <= w_data[6:0];
					`ADDR_P0_DIR: p0.dir <= w_data[6:0];
					`ADDR_P0_PLU: p0.plu <= w_data[6:0];
					`ADDR_P1_OUT: p1.dout <= w_data[4:0];
					`ADDR_P1_DIR: p1.dir <= w_data[4:0];
					`ADDR_P1_PLU: p1.plu <= w_data[4:0];
					`ADDR_RST_CTRL: begin
						reset_pin_port_bit <= w_data[0];
						sw_reset_req <= w_data[1];
					end
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Pin drivers, one tri-state cell per bit
	genvar gi;
	generate
		for (gi = 0; gi < `P0_WIDTH; gi++) begin : g_p0
			assign port0_oe[gi] = p0.dir[gi];
			assign port0_out[gi] = p0.dout[gi];
			assign port0_pullup_en[gi] = p0.plu[gi] && !p0.dir[gi];
		end
		for (gi = 0; gi < `P1_WIDTH; gi++) begin : g_p1
			assign port1_oe[gi] = p1.dir[gi];
			assign port1_out[gi] = p1.dout[gi];
			assign port1_pullup_en[gi] = p1.plu[gi] && !p1.dir[gi];
		end
	endgenerate

	// ==========================================================
	// Software reset pulls the pad low for a fixed time
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			swrst_cnt <= 8'h00;
		end else if (sw_reset_req && !reset_pin_port_bit) begin
			swrst_cnt <= `SWRST_PULSE_CYCLES;
		end else if (swrst_cnt != 8'h00) begin
			swrst_cnt <= swrst_cnt - 8'h01;
		end
	end

	assign pin_low = (swrst_cnt != 8'h00);
	// Open-drain: data fixed low, only the enable moves
	assign reset_pin_active_low_out = 1'b0;
	assign reset_pin_active_low_oe = pin_low;
	assign reset_pin_pullup_en = 1'b1;

	// ==========================================================
	// Reset sequencer: hold, stabilise, run
	// A low pin during the wait drops back to hold and restarts the count
	always_comb begin
		next_state = state;
		case (state)
			gpio_pins_pkg::RST_HOLD:
				if (reset_pin_active_low_in)
					next_state = gpio_pins_pkg::RST_STAB;
			gpio_pins_pkg::RST_STAB:
				if (!reset_pin_active_low_in)
					next_state = gpio_pins_pkg::RST_HOLD;
				else if (stab_cnt == `STAB_CYCLES - 16'h0001)
					next_state = gpio_pins_pkg::RST_RUN;
			gpio_pins_pkg::RST_RUN:
				if (!reset_pin_active_low_in)
					next_state = gpio_pins_pkg::RST_HOLD;
			default: next_state = gpio_pins_pkg::RST_HOLD;
		endcase
	end

	// Power-on starts in hold so a low pin at power-up resets
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= gpio_pins_pkg::RST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stab_cnt <= 16'h0000;
		end else if (state == gpio_pins_pkg::RST_STAB) begin
			stab_cnt <= stab_cnt + 16'h0001;
		end else begin
			stab_cnt <= 16'h0000;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reset_irq_req <= 1'b0;
		end else begin
			reset_irq_req <= (state == gpio_pins_pkg::RST_STAB) &&
				(next_state == gpio_pins_pkg::RST_RUN);
		end
	end

	assign core_reset = (state != gpio_pins_pkg::RST_RUN);

	// ==========================================================
	// Read channel
	// rdata loads only on accept, so it stands as long as rvalid waits
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp = 2'b00;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
				`ADDR_P0_OUT: s_axi_rdata <= {25'h0, p0.dout};
				`ADDR_P0_DIR: s_axi_rdata <= {25'h0, p0.dir};
				`ADDR_P0_PLU: s_axi_rdata <= {25'h0, p0.plu};
				`ADDR_P0_IN: s_axi_rdata <= {25'h0, port0_in};
				`ADDR_P1_OUT: s_axi_rdata <= {27'h0, p1.dout};
				`ADDR_P1_DIR: s_axi_rdata <= {27'h0, p1.dir};
				`ADDR_P1_PLU: s_axi_rdata <= {27'h0, p1.plu};
				`ADDR_P1_IN: s_axi_rdata <= {27'h0, port1_in};
				`ADDR_RST_CTRL: s_axi_rdata <= {31'h0, reset_pin_port_bit};
				`ADDR_RST_STAT: s_axi_rdata <= {29'h0, pin_low,
					reset_pin_active_low_in, core_reset};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	// Length of the current pull-low run, counted from the pin enable
	// itself so the pulse width is not judged by the loader's own counter
	logic [7:0] chk_low_run;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chk_low_run <= 8'h00;
		end else if (reset_pin_active_low_oe) begin
			chk_low_run <= chk_low_run + 8'h01;
		end else begin
			chk_low_run <= 8'h00;
		end
	end

	a_por_inputs: assert property (@(posedge ref_clk)
		$fell(sys_rst) |-> (port0_oe == 7'h00 && port1_oe == 5'h00 &&
		port0_pullup_en == 7'h00 && port1_pullup_en == 5'h00))
		else $error("ports not inputs after reset");
	a_dir_follow0: assert property (@(posedge ref_clk) disable iff (sys_rst)
		port0_oe == p0.dir)
		else $error("port0 direction mismatch");
	a_dir_follow1: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$changed(p1.dir) |-> port1_oe == p1.dir)
		else $error("port1 direction mismatch");
	a_width_p0: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(p0.dir[6] && p0.dout[6]) |-> port0_oe[6] && port0_out[6])
		else $error("port0 bit6 not driven");
	a_width_p1: assert property (@(posedge ref_clk) disable iff (sys_rst)
		p1.dir[4] |-> port1_oe[4])
		else $error("port1 bit4 not driven");
	a_hold_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!reset_pin_active_low_in |=> core_reset)
		else $error("core not held in reset");
	a_stab_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == gpio_pins_pkg::RST_HOLD && reset_pin_active_low_in)
		|=> core_reset [*8])
		else $error("reset released too early");
	a_irq_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reset_irq_req |-> $past(stab_cnt) == `STAB_CYCLES - 16'h0001)
		else $error("stabilisation count wrong");
	a_swrst_drive: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(sw_reset_req && !reset_pin_port_bit) |=> reset_pin_active_low_oe)
		else $error("software reset pulse missing");
	a_swrst_len: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$fell(reset_pin_active_low_oe) |->
		chk_low_run == `SWRST_PULSE_CYCLES)
		else $error("software reset pulse length wrong");
	a_open_drain: assert property (@(posedge ref_clk)
		reset_pin_active_low_out == 1'b0 && reset_pin_pullup_en)
		else $error("reset pin driven high");
	c_run: cover property (@(posedge ref_clk) reset_irq_req);
	c_swrst: cover property (@(posedge ref_clk) $rose(reset_pin_active_low_oe));
	c_wr: cover property (@(posedge ref_clk) s_axi_bvalid && s_axi_bready);

	// Pull-ups never fight an output driver
	a_pu_off0: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(port0_pullup_en & port0_oe) == 7'h00)
		else $error("port0 pull-up on an output bit");
	a_pu_off1: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(port1_pullup_en & port1_oe) == 5'h00)
		else $error("port1 pull-up on an output bit");

	// Reset sequencing around the interrupt request
	a_irq_pulse: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		reset_irq_req |=> !reset_irq_req)
		else $error("reset request longer than one cycle");
	a_irq_release: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		reset_irq_req |-> !core_reset)
		else $error("core still in reset at request");
	a_run_needs_irq: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$fell(core_reset) |-> reset_irq_req)
		else $error("core released without request");
	a_stab_abort: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state == gpio_pins_pkg::RST_STAB && !reset_pin_active_low_in)
		|=> state == gpio_pins_pkg::RST_HOLD)
		else $error("low pin did not restart the wait");

	// Software reset gating and self reset
	a_swrst_gate: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(sw_reset_req && reset_pin_port_bit && !pin_low)
		|=> !reset_pin_active_low_oe)
		else $error("pin pulled low with port bit set");
	a_swrst_release: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$fell(reset_pin_active_low_oe) |-> core_reset)
		else $error("self reset did not hold the core");
	a_sw_selfclear: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		sw_reset_req |=> !sw_reset_req)
		else $error("software reset request stuck");
	c_abort: cover property (@(posedge ref_clk)
		state == gpio_pins_pkg::RST_STAB && !reset_pin_active_low_in);
	c_rd: cover property (@(posedge ref_clk) s_axi_rvalid && s_axi_rready);
endmodule : gpio_pins
`default_nettype wire

// ===== bench/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
	// Clock, from a resonator only, so no stop or slow mode
	input wire logic ref_clk,
	// Port pads, port1 in bits 11:7
	input wire logic [11:0] dout,
	input wire logic [11:0] oe,
	input wire logic [11:0] pu,
	input wire logic [11:0] ext_val,
	input wire logic [11:0] ext_en,
	output logic [11:0] pad,
	// Reset pad
	input wire logic rst_oe,
	input wire logic rst_pull,
	output logic rst_pad
);
	logic [11:0] wander = 12'ha5a;
	// An undriven pad must not read as a steady level
	always_ff @(posedge ref_clk) begin
		wander <= ~wander;
	end
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			if (oe[i]) pad[i] = dout[i];
			else if (ext_en[i]) pad[i] = ext_val[i];
			else if (pu[i]) pad[i] = 1'b1;
			else pad[i] = wander[i];
		end
	end
	// Open drain with pull-up: low while either side pulls
	assign rst_pad = ~(rst_oe | rst_pull);
endmodule : board_model
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [11:0] ext_val = 12'h000;
	logic [11:0] ext_en = 12'h000;
	logic rst_pull = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rst_out, rst_oe;
	logic rst_pu, core_reset, irq, rst_pad;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [11:0] pad, pad_out, pad_oe, pad_pu;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	always #10 ref_clk = ~ref_clk;
	gpio_pins u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.port0_in(pad[6:0]), .port0_out(pad_out[6:0]),
		.port0_oe(pad_oe[6:0]), .port0_pullup_en(pad_pu[6:0]),
		.port1_in(pad[11:7]), .port1_out(pad_out[11:7]),
		.port1_oe(pad_oe[11:7]), .port1_pullup_en(pad_pu[11:7]),
		.reset_pin_active_low_in(rst_pad), .reset_pin_active_low_out(rst_out),
		.reset_pin_active_low_oe(rst_oe), .reset_pin_pullup_en(rst_pu),
		.core_reset(core_reset), .reset_irq_req(irq));
	board_model u_board (.ref_clk(ref_clk), .dout(pad_out), .oe(pad_oe),
		.pu(pad_pu), .ext_val(ext_val), .ext_en(ext_en), .pad(pad),
		.rst_oe(rst_oe), .rst_pull(rst_pull), .rst_pad(rst_pad));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		logic [1:0] b_resp;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge ref_clk);
			aw_t = awready;
			w_t = wready;
			b_t = bvalid;
			b_resp = bresp;
			@(posedge ref_clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end while (!b_t);
		bready <= 1'b0;
		check({30'h0, b_resp}, 32'h0000_0000);
	endtask : axi_write
	task automatic axi_read(input logic [11:0] a, output logic [31:0] d);
		logic ar_t, r_t;
		logic [1:0] r_resp;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge ref_clk);
			ar_t = arready;
			r_t = rvalid;
			d = rdata;
			r_resp = rresp;
			@(posedge ref_clk);
			if (ar_t) arvalid <= 1'b0;
		end while (!r_t);
		rready <= 1'b0;
		check({30'h0, r_resp}, 32'h0000_0000);
	endtask : axi_read
	task automatic wait_ready();
		int n = 0;
		while (irq !== 1'b1 && n < 1100) begin
			@(negedge ref_clk);
			n++;
		end
		check(32'(n >= 1022 && n <= 1032), 32'h1);
		@(negedge ref_clk);
		check({31'h0, core_reset}, 32'h0);
		$display("stabilise wait done");
	endtask : wait_ready
	task automatic t_port(input logic [11:0] base, input int sh);
		logic [6:0] m;
		logic [31:0] d;
		m = (sh == 0) ? 7'h7f : 7'h1f;
		axi_write(base + 12'h004, 32'h0000_0055);
		axi_write(base, 32'h0000_0033);
		axi_write(base + 12'h008, 32'h0000_007f);
		ext_val <= 12'(7'h0a) << sh;
		ext_en <= 12'(7'h2a & m) << sh;
		repeat (3) @(negedge ref_clk);
		check(32'((pad_oe >> sh) & 12'(m)), 32'(7'h55 & m));
		check(32'((pad_out & pad_oe) >> sh), 32'(7'h11 & m));
		check(32'((pad_pu >> sh) & 12'(m)), 32'(7'h2a & m));
		axi_read(base + 12'h00c, d);
		check(d, 32'(7'h1b & m));
		axi_write(base + 12'h004, 32'h0000_0000);
		ext_en <= 12'h000;
		$display("port test done");
	endtask : t_port
	task automatic t_pins();
		logic [31:0] d;
		axi_read(12'h040, d);
		check(d, 32'h0000_0000);
		@(posedge ref_clk);
		rst_pull <= 1'b1;
		repeat (3) @(negedge ref_clk);
		check({30'h0, core_reset, rst_oe}, 32'h2);
		@(posedge ref_clk);
		rst_pull <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rst_pull <= 1'b1;
		repeat (2) @(negedge ref_clk);
		check({31'h0, core_reset}, 32'h1);
		@(posedge ref_clk);
		rst_pull <= 1'b0;
		wait_ready();
		$display("pin reset done");
	endtask : t_pins
	task automatic t_swreset();
		int n = 0;
		logic [31:0] d;
		axi_write(12'h020, 32'h0000_0003);
		repeat (4) @(negedge ref_clk);
		check({31'h0, rst_oe}, 32'h0000_0000);
		axi_write(12'h020, 32'h0000_0002);
		@(negedge ref_clk);
		while (rst_oe !== 1'b1 && n < 8) begin
			@(negedge ref_clk);
			n++;
		end
		check({29'h0, rst_out, rst_pad, rst_oe}, 32'h1);
		n = 0;
		while (rst_oe === 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		check(32'(n), 32'h0000_0010);
		wait_ready();
		axi_read(12'h024, d);
		check(d, 32'h0000_0002);
		axi_read(12'h020, d);
		check(d, 32'h0000_0000);
		$display("software reset done");
	endtask : t_swreset
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(negedge ref_clk);
		check({8'h00, pad_oe, pad_pu}, 32'h0000_0000);
		check({29'h0, core_reset, rst_pu, rst_oe}, 32'h6);
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		wait_ready();
		t_port(12'h000, 0);
		t_port(12'h010, 7);
		t_pins();
		t_swreset();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
